// ---- verilog/mcc_params.svh ----
// Purpose: Offsets, reset values, field positions and timing figures
// Assumes: 8-bit registers on the management register port
// Notes:   Included by every design file of the block except the package
`ifndef MCC_PARAMS_SVH
`define MCC_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MCC_DIODE_AVG_OFS    8'h40
`define MCC_SRC_CFG_OFS      8'h50
`define MCC_SHUNT_CFG_OFS    8'h51
`define MCC_CRIT_OFS         8'h37

// ****************************************************************
// Reset values
// ****************************************************************
`define MCC_DIODE_AVG_RST    8'h00
`define MCC_SRC_CFG_RST      8'h80
`define MCC_SHUNT_CFG_RST    8'h03
`define MCC_UNMAPPED_READ    8'h00

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define MCC_DIODE_AVG_BITS   6
`define MCC_CRIT_CHANNELS    6
`define MCC_CH_SHUNT         5
`define MCC_CH_SOURCE        4

// ****************************************************************
// Timing
// ****************************************************************
`define MCC_SAMPLE_TIME_US   82000
`define MCC_CLK_MHZ          100
`define MCC_PERIOD_CNT_BITS  24
`define MCC_SLOT_CNT_BITS    6

`endif

// ---- verilog/mcc_pkg.sv ----
// Purpose: Types shared by the configuration and critical status block
// Assumes: Field layouts follow the register map in mcc_params.svh
// Notes:   Structs are packed so they overlay the register bytes
package mcc_pkg;

    // ****************************************************************
    // Register layouts
    // ****************************************************************
    typedef struct packed {
        logic [1:0] shunt_queue;
        logic [1:0] shunt_averaging;
        logic [1:0] shunt_sample_period;
        logic [1:0] shunt_full_scale;
    } mcc_shunt_cfg_t;

    typedef struct packed {
        logic       spike_output_select;
        logic [2:0] unused;
        logic [1:0] source_queue;
        logic [1:0] source_averaging;
    } mcc_src_cfg_t;

    // ****************************************************************
    // Register port request
    // ****************************************************************
    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcc_link_req_t;

endpackage

// ---- verilog/mcc_qualifier.sv ----
// Purpose: Consecutive out-of-limit qualifier for one channel
// Assumes: sampleValid is a one-cycle pulse per finished reading
// Notes:   Event pulse follows the qualifying reading by one cycle
`timescale 1ns/100ps
`include "mcc_params.svh"
module mcc_qualifier
    import mcc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       sampleValid,
    input  wire logic       outOfLimit,
    input  wire logic [1:0] queueSel,
    output logic            limitEvent_reg
);
    logic [1:0] count_reg;
    logic       reached;

    // Code n asks for n+1 readings in a row
    assign reached = (count_reg >= queueSel);

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg      <= 2'h0;
            limitEvent_reg <= 1'b0;
        end else begin
            limitEvent_reg <= sampleValid && outOfLimit && reached;
            if (sampleValid && !outOfLimit) begin
                count_reg <= 2'h0;
            end else if (sampleValid && !reached) begin
                count_reg <= count_reg + 2'h1;
            end
        end
    end

    property p_restart;
        @(posedge clk) disable iff (rst)
        (sampleValid && !outOfLimit) |=> (count_reg == 2'h0) && !limitEvent_reg;
    endproperty
    a_restart: assert property (p_restart) else $error("count not restarted");

    property p_queue_depth;
        @(posedge clk) disable iff (rst)
        limitEvent_reg |-> $past(outOfLimit) && ($past(count_reg) >= $past(queueSel));
    endproperty
    a_queue_depth: assert property (p_queue_depth) else $error("event before queue depth");

    c_queue_full: cover property (@(posedge clk) limitEvent_reg && queueSel == 2'h3);

endmodule // mcc_qualifier

// ---- verilog/mcc_config_crit.sv ----
// How it works
// - Shunt and source critical flags set at limit; each drives critical pin.
// - Three remote and one local critical flags set at limit; each drives pin.
// - Reading the critical status register leaves every flag unchanged.
// - Flags clear below limit minus hysteresis; summary clears when all clear.
// - Two-bit averaging field per remote diode: off, 2, 4, 8 samples.
// - Routing bit, reset one, sends spikes to critical pin or alert.
// - Peak mask blocks spike alerts routed to the alert pin.
// - Spikes routed to the critical pin assert it regardless of masks.
// - Spike alerts appear only while alert pin runs in comparator mode.
// - Source queue field needs 1 to 4 consecutive out-of-limit readings.
// - Source averaging field: off by default, then 2, 4, 8 samples.
// - Shunt queue field needs 1 to 4 consecutive out-of-limit readings.
// - Shunt averaging field averages 1, 2, 4 or 8 sampling periods.
// - Shunt sampling period codes give 82, 82, 164, 328 ms.
// - Shunt result updates every sampling period times averaging count.
// - Shunt full-scale field selects 10, 20, 40, 80 mV; reset 80 mV.
//
// Purpose: Measurement configuration and critical limit status
// Assumes: Front end readings arrive on clk; register port runs on linkClk
// Notes:   Register port crosses to clk by a toggle handshake
`timescale 1ns/100ps
`include "mcc_params.svh"
module mcc_config_crit
    import mcc_pkg::*;
#(
    parameter int unsigned BASE_PERIOD_CYC = `MCC_SAMPLE_TIME_US * `MCC_CLK_MHZ
)
(
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            linkClk,
    input  wire logic                            linkReqValid,
    input  wire mcc_link_req_t                   linkReq,
    output logic                                 linkBusy_reg,
    output logic                                 linkAck_reg,
    output logic [7:0]                           linkRdata_reg,
    input  wire logic [`MCC_CRIT_CHANNELS-1:0]   critSampleValid,
    input  wire logic [`MCC_CRIT_CHANNELS-1:0]   atCritLimit,
    input  wire logic [`MCC_CRIT_CHANNELS-1:0]   belowCritHyst,
    input  wire logic                            shuntSampleValid,
    input  wire logic                            shuntOutOfLimit,
    input  wire logic                            sourceSampleValid,
    input  wire logic                            sourceOutOfLimit,
    input  wire logic                            spikeDetect,
    input  wire logic                            peakMask,
    input  wire logic                            alertComparatorMode,
    output logic                                 critical_out_pin_n_reg,
    output logic                                 spikeAlert_reg,
    output logic                                 criticalSummary_reg,
    output logic                                 shuntLimitEvent_reg,
    output logic                                 sourceLimitEvent_reg,
    output logic                                 shuntUpdate_reg,
    output mcc_shunt_cfg_t                       shuntActive_reg,
    output logic [1:0]                           source_averaging_reg,
    output logic [`MCC_DIODE_AVG_BITS-1:0]       diodeAvgActive_reg
);

    // ****************************************************************
    // Link domain: capture request, toggle across
    // ****************************************************************
    mcc_link_req_t linkHold_reg;
    logic          reqToggle_reg;
    logic          linkRst1_reg;
    logic          linkRst2_reg;
    logic          ackSync1_reg;
    logic          ackSync2_reg;
    logic          ackSync3_reg;
    logic          ackToggle_reg;
    logic [7:0]    coreRdata_reg;
    logic          linkAckSeen;
    logic          linkTake;

    assign linkAckSeen = ackSync2_reg ^ ackSync3_reg;
    assign linkTake    = linkReqValid && !linkBusy_reg;

    // Reset brought into the link domain before use
    always_ff @(posedge linkClk) begin
        linkRst1_reg <= rst;
        linkRst2_reg <= linkRst1_reg;
    end

    always_ff @(posedge linkClk) begin
        if (linkRst2_reg) begin
            linkHold_reg  <= '0;
            reqToggle_reg <= 1'b0;
            linkBusy_reg  <= 1'b0;
            linkAck_reg   <= 1'b0;
            linkRdata_reg <= `MCC_UNMAPPED_READ;
            ackSync1_reg  <= 1'b0;
            ackSync2_reg  <= 1'b0;
            ackSync3_reg  <= 1'b0;
        end else begin
            ackSync1_reg <= ackToggle_reg;
            ackSync2_reg <= ackSync1_reg;
            ackSync3_reg <= ackSync2_reg;
            linkAck_reg  <= linkAckSeen;
            if (linkTake) begin
                linkHold_reg  <= linkReq;
                reqToggle_reg <= ~reqToggle_reg;
                linkBusy_reg  <= 1'b1;
            end else if (linkAckSeen) begin
                // Core data held still since its toggle went out
                linkRdata_reg <= coreRdata_reg;
                linkBusy_reg  <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Core domain: request detect and register decode
    // ****************************************************************
    logic           reqSync1_reg;
    logic           reqSync2_reg;
    logic           reqSync3_reg;
    logic           coreReq;
    logic           coreWrite;
    logic           coreRead;
    logic           hitDiode;
    logic           hitSrc;
    logic           hitShunt;
    logic           hitCrit;
    logic [7:0]     readMux;
    logic [7:0]     diodeAvg_reg;
    mcc_src_cfg_t   srcCfg_reg;
    mcc_shunt_cfg_t shuntCfg_reg;
    logic [7:0]     critByte;
    logic [`MCC_CRIT_CHANNELS-1:0] critFlags_reg;

    assign coreReq   = reqSync2_reg ^ reqSync3_reg;
    assign coreWrite = coreReq && linkHold_reg.write;
    assign coreRead  = coreReq && !linkHold_reg.write;
    assign hitDiode  = (linkHold_reg.addr == `MCC_DIODE_AVG_OFS);
    assign hitSrc    = (linkHold_reg.addr == `MCC_SRC_CFG_OFS);
    assign hitShunt  = (linkHold_reg.addr == `MCC_SHUNT_CFG_OFS);
    assign hitCrit   = (linkHold_reg.addr == `MCC_CRIT_OFS);

    // Flags sit at bits 7, 6 and 3..0; bits 5..4 read zero
    assign critByte = {critFlags_reg[`MCC_CH_SHUNT], critFlags_reg[`MCC_CH_SOURCE],
                       2'h0, critFlags_reg[3:0]};

    assign readMux = hitDiode ? diodeAvg_reg :
                     hitSrc   ? {srcCfg_reg.spike_output_select, 3'h0,
                                 srcCfg_reg.source_queue, srcCfg_reg.source_averaging} :
                     hitShunt ? shuntCfg_reg :
                     hitCrit  ? critByte : `MCC_UNMAPPED_READ;

    always_ff @(posedge clk) begin
        if (rst) begin
            reqSync1_reg  <= 1'b0;
            reqSync2_reg  <= 1'b0;
            reqSync3_reg  <= 1'b0;
            ackToggle_reg <= 1'b0;
            coreRdata_reg <= `MCC_UNMAPPED_READ;
        end else begin
            reqSync1_reg <= reqToggle_reg;
            reqSync2_reg <= reqSync1_reg;
            reqSync3_reg <= reqSync2_reg;
            if (coreReq) begin
                ackToggle_reg <= ~ackToggle_reg;
                // Read has no side effect on the critical flags
                coreRdata_reg <= coreRead ? readMux : coreRdata_reg;
            end
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            diodeAvg_reg <= `MCC_DIODE_AVG_RST;
            srcCfg_reg   <= `MCC_SRC_CFG_RST;
            shuntCfg_reg <= `MCC_SHUNT_CFG_RST;
        end else if (coreWrite) begin
            if (hitDiode) begin
                diodeAvg_reg <= {2'h0, linkHold_reg.wdata[`MCC_DIODE_AVG_BITS-1:0]};
            end else if (hitSrc) begin
                srcCfg_reg <= {linkHold_reg.wdata[7], 3'h0, linkHold_reg.wdata[3:0]};
            end else if (hitShunt) begin
                shuntCfg_reg <= linkHold_reg.wdata;
            end
        end
    end

    // ****************************************************************
    // Critical flags and pin
    // ****************************************************************
    logic [`MCC_CRIT_CHANNELS-1:0] critSet;
    logic [`MCC_CRIT_CHANNELS-1:0] critClr;
    logic [`MCC_CRIT_CHANNELS-1:0] critFlags_next;
    logic                          spikeToCrit;
    logic                          spikeToAlert;

    assign critSet        = critSampleValid & atCritLimit;
    assign critClr        = critSampleValid & belowCritHyst & ~atCritLimit;
    assign critFlags_next = (critFlags_reg & ~critClr) | critSet;
    assign spikeToCrit    = spikeDetect && srcCfg_reg.spike_output_select;
    // Alert path is only meaningful in comparator mode; latched mode drops it
    assign spikeToAlert   = spikeDetect && !srcCfg_reg.spike_output_select
                            && !peakMask && alertComparatorMode;

    always_ff @(posedge clk) begin
        if (rst) begin
            critFlags_reg          <= '0;
            critical_out_pin_n_reg <= 1'b1;
            spikeAlert_reg         <= 1'b0;
            criticalSummary_reg    <= 1'b0;
        end else begin
            critFlags_reg          <= critFlags_next;
            critical_out_pin_n_reg <= !((|critFlags_reg) || spikeToCrit);
            spikeAlert_reg         <= spikeToAlert;
            criticalSummary_reg    <= |critFlags_reg;
        end
    end

    // ****************************************************************
    // Out-of-limit qualifiers
    // ****************************************************************
    mcc_qualifier u_shunt_qual (
        .clk            (clk),
        .rst            (rst),
        .sampleValid    (shuntSampleValid),
        .outOfLimit     (shuntOutOfLimit),
        .queueSel       (shuntCfg_reg.shunt_queue),
        .limitEvent_reg (shuntLimitEvent_reg)
    );

    mcc_qualifier u_source_qual (
        .clk            (clk),
        .rst            (rst),
        .sampleValid    (sourceSampleValid),
        .outOfLimit     (sourceOutOfLimit),
        .queueSel       (srcCfg_reg.source_queue),
        .limitEvent_reg (sourceLimitEvent_reg)
    );

    // ****************************************************************
    // Measurement period timing
    // ****************************************************************
    localparam logic [`MCC_PERIOD_CNT_BITS-1:0] BASE_LAST =
        `MCC_PERIOD_CNT_BITS'(BASE_PERIOD_CYC - 1);

    logic [`MCC_PERIOD_CNT_BITS-1:0] baseCnt_reg;
    logic [`MCC_SLOT_CNT_BITS-1:0]   slotCnt_reg;
    logic [`MCC_SLOT_CNT_BITS-1:0]   periodMult;
    logic [`MCC_SLOT_CNT_BITS-1:0]   slotLast;
    logic                            baseEnd;
    logic                            periodEnd;

    // Codes 00 and 01 share the shortest period
    assign periodMult = shuntActive_reg.shunt_sample_period[1] ?
                        (shuntActive_reg.shunt_sample_period[0] ? 6'h04 : 6'h02) :
                        6'h01;
    assign slotLast   = (periodMult << shuntActive_reg.shunt_averaging) - 6'h01;
    assign baseEnd    = (baseCnt_reg == BASE_LAST);
    assign periodEnd  = baseEnd && (slotCnt_reg == slotLast);

    always_ff @(posedge clk) begin
        if (rst) begin
            baseCnt_reg <= '0;
            slotCnt_reg <= '0;
        end else if (baseEnd) begin
            baseCnt_reg <= '0;
            slotCnt_reg <= periodEnd ? 6'h00 : slotCnt_reg + 6'h01;
        end else begin
            baseCnt_reg <= baseCnt_reg + `MCC_PERIOD_CNT_BITS'(1);
        end
    end

    // Shadow copies only move at a period boundary
    always_ff @(posedge clk) begin
        if (rst) begin
            shuntUpdate_reg      <= 1'b0;
            shuntActive_reg      <= `MCC_SHUNT_CFG_RST;
            source_averaging_reg <= 2'h0;
            diodeAvgActive_reg   <= '0;
        end else begin
            shuntUpdate_reg <= periodEnd;
            if (periodEnd) begin
                shuntActive_reg      <= shuntCfg_reg;
                source_averaging_reg <= srcCfg_reg.source_averaging;
                diodeAvgActive_reg   <= diodeAvg_reg[`MCC_DIODE_AVG_BITS-1:0];
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_crit_voltage;
        @(posedge clk) disable iff (rst)
        (|critFlags_reg[`MCC_CH_SHUNT:`MCC_CH_SOURCE]) |=> !critical_out_pin_n_reg;
    endproperty
    a_crit_voltage: assert property (p_crit_voltage) else $error("pin idle, volt flag");

    property p_crit_temp;
        @(posedge clk) disable iff (rst)
        critSampleValid[0] && atCritLimit[0] ##1 1'b1 |=> !critical_out_pin_n_reg;
    endproperty
    a_crit_temp: assert property (p_crit_temp) else $error("pin idle, temp flag");

    property p_read_keeps;
        @(posedge clk) disable iff (rst)
        coreRead && hitCrit && (critSampleValid == '0) |=> $stable(critFlags_reg);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read changed flags");

    property p_auto_clear;
        @(posedge clk) disable iff (rst)
        critSampleValid[3] && belowCritHyst[3] && !atCritLimit[3]
            |=> !critFlags_reg[3] ##1 (criticalSummary_reg == (|$past(critFlags_reg)));
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("flag did not clear");

    property p_diode_write;
        @(posedge clk) disable iff (rst)
        coreWrite && hitDiode |=> diodeAvg_reg[5:0] == $past(linkHold_reg.wdata[5:0]);
    endproperty
    a_diode_write: assert property (p_diode_write) else $error("diode avg lost");

    property p_spike_crit;
        @(posedge clk) disable iff (rst)
        spikeDetect && srcCfg_reg.spike_output_select
            |=> !critical_out_pin_n_reg && !spikeAlert_reg;
    endproperty
    a_spike_crit: assert property (p_spike_crit) else $error("spike not on pin");

    property p_spike_mask;
        @(posedge clk) disable iff (rst)
        peakMask || srcCfg_reg.spike_output_select |=> !spikeAlert_reg;
    endproperty
    a_spike_mask: assert property (p_spike_mask) else $error("masked spike alerted");

    property p_spike_cmp;
        @(posedge clk) disable iff (rst)
        !alertComparatorMode |=> !spikeAlert_reg;
    endproperty
    a_spike_cmp: assert property (p_spike_cmp) else $error("alert outside comparator");

    property p_shadow_hold;
        @(posedge clk) disable iff (rst)
        !periodEnd |=> $stable(shuntActive_reg) && $stable(diodeAvgActive_reg);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) else $error("config moved mid period");

    property p_update_spacing;
        @(posedge clk) disable iff (rst)
        shuntUpdate_reg |=> !shuntUpdate_reg [*2];
    endproperty
    a_update_spacing: assert property (p_update_spacing) else $error("updates too close");

    c_crit_set:   cover property (@(posedge clk) disable iff (rst) !critical_out_pin_n_reg);
    c_spike_alrt: cover property (@(posedge clk) disable iff (rst) spikeAlert_reg);
    c_update:     cover property (@(posedge clk) disable iff (rst) shuntUpdate_reg);
    c_read_crit:  cover property (@(posedge clk) disable iff (rst) coreRead && hitCrit);

endmodule // mcc_config_crit

// ---- test/mcc_host_model.sv ----
// Purpose: Register port host model
// Assumes: A request is taken on linkClk while linkBusy_reg is low
// Notes:   Released request lines show inverted data, not a stale copy
`timescale 1ns/100ps
module mcc_host_model
    import mcc_pkg::*;
(
    input  wire logic       linkClk,
    input  wire logic       linkBusy_reg,
    input  wire logic       linkAck_reg,
    input  wire logic [7:0] linkRdata_reg,
    output logic            linkReqValid,
    output mcc_link_req_t   linkReq
);
    // ********
    // One outstanding request
    // ********
    initial begin
        linkReqValid = 1'b0;
        linkReq = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] r, output bit ok);
        int n;
        bit tk;
        ok = 1'b0;
        tk = 1'b0;
        r = 8'h00;
        @(posedge linkClk);
        linkReqValid <= 1'b1;
        linkReq <= '{w, a, d};
        for (n = 0; n < 40 && !tk; n++) begin
            @(posedge linkClk);
            tk = (linkBusy_reg === 1'b0);
        end
        // Released lines must not look like a valid request
        linkReqValid <= 1'b0;
        linkReq <= ~linkReq;
        for (n = 0; n < 40 && tk && !ok; n++) begin
            @(posedge linkClk);
            if (linkAck_reg === 1'b1) begin
                ok = 1'b1;
                r = linkRdata_reg;
            end
        end
    endtask
endmodule // mcc_host_model

// ---- test/tb_measurement_config_and_crit_status.sv ----
// Purpose: Self-checking bench of the configuration and critical status block
// Assumes: Short base period of 10 core cycles
// Notes:   Seeded random register data with fixed corner cases
`timescale 1ns/100ps
`include "mcc_params.svh"
module tb_measurement_config_and_crit_status
    import mcc_pkg::*;
;
    logic           clk, rst, linkClk, linkReqValid, linkBusy, linkAck;
    logic           shValid, shOut, srcValid, srcOut, spike, pkMask, compMode;
    logic           pinN, spikeAlert, critSum, shEvt, srcEvt, shUpd, e;
    logic [5:0]     critValid, atCrit, belowHyst, dAvg;
    logic [1:0]     srcAvg;
    logic [7:0]     linkRdata, d, r;
    mcc_link_req_t  linkReq;
    mcc_shunt_cfg_t shAct;
    int             fail_count, n_compared, i, k, q, s, c;
    logic [7:0]     ofs [5] = '{8'h40, 8'h50, 8'h51, 8'h37, 8'h7F};
    logic [7:0]     rstv [5] = '{8'h00, 8'h80, 8'h03, 8'h00, 8'h00};

    mcc_config_crit #(.BASE_PERIOD_CYC(10)) u_dut (.clk(clk), .rst(rst),
        .linkClk(linkClk), .linkReqValid(linkReqValid), .linkReq(linkReq),
        .linkBusy_reg(linkBusy), .linkAck_reg(linkAck), .linkRdata_reg(linkRdata),
        .critSampleValid(critValid), .atCritLimit(atCrit), .belowCritHyst(belowHyst),
        .shuntSampleValid(shValid), .shuntOutOfLimit(shOut),
        .sourceSampleValid(srcValid), .sourceOutOfLimit(srcOut),
        .spikeDetect(spike), .peakMask(pkMask), .alertComparatorMode(compMode),
        .critical_out_pin_n_reg(pinN), .spikeAlert_reg(spikeAlert),
        .criticalSummary_reg(critSum), .shuntLimitEvent_reg(shEvt),
        .sourceLimitEvent_reg(srcEvt), .shuntUpdate_reg(shUpd),
        .shuntActive_reg(shAct), .source_averaging_reg(srcAvg),
        .diodeAvgActive_reg(dAvg));
    mcc_host_model u_host (.linkClk(linkClk), .linkBusy_reg(linkBusy),
        .linkAck_reg(linkAck), .linkRdata_reg(linkRdata),
        .linkReqValid(linkReqValid), .linkReq(linkReq));

    // ********
    // Checking helpers
    // ********
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tmo();
        fail_count++;
        $display("mismatch at %0t: wait timed out", $time);
        end_sim();
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] dd);
        bit ok;
        u_host.xfer(w, a, dd, r, ok);
        if (!ok) begin
            tmo();
        end
    endtask
    task automatic waitUpd();
        for (c = 1; c <= 1000; c++) begin
            @(posedge clk);
            #1;
            if (shUpd === 1'b1) begin
                return;
            end
        end
        tmo();
    endtask
    // Period in core cycles: base 10 times period factor times averages
    function automatic logic [15:0] perCyc(input logic [7:0] v);
        return 16'(10 * (v[3] ? (v[2] ? 4 : 2) : 1) * (1 << v[5:4]));
    endfunction
    task automatic crit(input int ch, input logic at, input logic bl);
        @(posedge clk);
        critValid <= 6'h01 << ch;
        atCrit <= {6{at}};
        belowHyst <= {6{bl}};
        @(posedge clk);
        critValid <= 6'h00;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Event pulses one edge after the reading, for one cycle only
    task automatic qual(input int src, input logic oo, input logic exp);
        @(posedge clk);
        shValid <= (src == 0);
        srcValid <= (src != 0);
        shOut <= oo;
        srcOut <= oo;
        @(posedge clk);
        shValid <= 1'b0;
        srcValid <= 1'b0;
        #1;
        e = src ? srcEvt : shEvt;
        chk(e, exp);
        @(posedge clk);
        #1;
        e = src ? srcEvt : shEvt;
        chk(e, 1'b0);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        linkClk = 1'b0;
        #3;
        forever #32 linkClk = ~linkClk;
    end

    // ********
    // Main sequence
    // ********
    initial begin
        {rst, shValid, shOut, srcValid, srcOut, spike, pkMask} = 7'h40;
        {critValid, atCrit, belowHyst} = '0;
        compMode = 1'b1;
        fail_count = 0;
        n_compared = 0;
        void'($urandom(32'h4cca));
        repeat (5) @(posedge linkClk);
        @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge linkClk);
        for (i = 0; i < 5; i++) begin
            rw(1'b0, ofs[i], 8'h00);
            chk(r, rstv[i]);
        end
        for (k = 0; k < 5; k++) begin
            d = (k == 0) ? 8'hFF : 8'($urandom);
            rw(1'b1, `MCC_SHUNT_CFG_OFS, d);
            rw(1'b1, `MCC_DIODE_AVG_OFS, d);
            rw(1'b1, `MCC_SRC_CFG_OFS, d);
            rw(1'b1, 8'h7F, ~d);
            for (i = 0; i < 3; i++) begin
                rw(1'b0, ofs[i], 8'h00);
                chk(r, d & (i == 0 ? 8'h3F : i == 1 ? 8'h8F : 8'hFF));
            end
            waitUpd();
            waitUpd();
            chk(c[15:0], perCyc(d));
            chk({shAct, srcAvg, dAvg}, {d, d[1:0], d[5:0]});
        end
        for (i = 0; i < 6; i++) begin
            crit(i, 1'b1, 1'b0);
            chk({critSum, pinN}, 2'b10);
            rw(1'b0, `MCC_CRIT_OFS, 8'h00);
            chk(r, i == 5 ? 8'h80 : i == 4 ? 8'h40 : 8'h01 << i);
            crit(i, 1'b0, 1'b0);
            rw(1'b0, `MCC_CRIT_OFS, 8'h00);
            chk(r, i == 5 ? 8'h80 : i == 4 ? 8'h40 : 8'h01 << i);
            crit(i, 1'b0, 1'b1);
            chk({critSum, pinN}, 2'b01);
        end
        for (q = 0; q < 4; q++) begin
            for (s = 0; s < 2; s++) begin
                rw(1'b1, s ? `MCC_SRC_CFG_OFS : `MCC_SHUNT_CFG_OFS,
                   s ? 8'(8'h80 | (q << 2)) : {q[1:0], 6'h03});
                // Count left by the previous depth must not carry over
                qual(s, 1'b0, 1'b0);
                for (k = 0; k < q; k++) qual(s, 1'b1, 1'b0);
                qual(s, 1'b0, 1'b0);
                for (k = 0; k < q; k++) qual(s, 1'b1, 1'b0);
                qual(s, 1'b1, 1'b1);
            end
        end
        for (k = 0; k < 8; k++) begin
            rw(1'b1, `MCC_SRC_CFG_OFS, {k[2], 7'h00});
            @(posedge clk);
            pkMask <= k[1];
            compMode <= k[0];
            spike <= 1'b1;
            repeat (2) @(posedge clk);
            #1;
            chk({pinN, spikeAlert}, {!k[2], !k[2] && !k[1] && k[0]});
            @(posedge clk);
            spike <= 1'b0;
        end
        end_sim();
    end
endmodule // tb_measurement_config_and_crit_status
